/* logic/pfs_port_select.sv */
// function select for port 1 and port 4: four select registers, per-pin
// decode, pad control and routing between pins and on-chip peripherals
// assumes the core's special-function bus and the peripherals share clk
//
// How it works
// [RULE_01] all four select registers reset to zero, so every pin starts as I/O
// [RULE_02] port 1: low bit clear is I/O; low set picks alt1, both set alt2
// [RULE_03] port 4 decodes its two select registers per pin exactly like port 1
// [RULE_04] port 1 alt1: timer 2 count/trigger, uart rx/tx, spi clock/rx/tx/select
// [RULE_05] port 1 alt2 ties pin i straight to analog converter channel i
// [RULE_06] port 4 alt1 pins 0-2 are counter array 0 modules, pin 3 its clock
// [RULE_07] port 4 alt1 pins 4-6 are counter array 1 modules, pin 7 its clock
// [RULE_08] port 4 alt2: timer 2 count/trigger, uart rx/tx, spi clock/rx/tx/select
// [RULE_09] every pin's function is chosen independently of all other pins
// [RULE_10] uart and spi pins get the strong high driver for one clock per rise
// [RULE_11] analog pins lose pull-up and both drivers and go straight to converter
// [RULE_12] all four select registers read back the last value written
`timescale 1ns/1ns
`default_nettype none
`include "pfs_regs.svh"

module pfs_port_select
#(
    parameter int PINS = `PFS_PORT_PINS
)
(
    // clock and reset
    input  wire logic            clk,
    input  wire logic            rst_b,
    input  wire logic            ce,
    // special-function register access
    input  wire logic [7:0]      sfr_addr,
    input  wire logic            sfr_wr,
    input  wire logic            sfr_rd,
    input  wire logic [7:0]      sfr_wdata,
    output wire logic            sfr_hit,
    output logic      [7:0]      sfr_rdata_r,
    // port 1 pads
    input  wire logic [PINS-1:0] p1_pad_in,
    output wire logic [PINS-1:0] p1_pad_out,
    output wire logic [PINS-1:0] p1_pad_oe,
    output wire logic [PINS-1:0] p1_pad_strong,
    output wire logic [PINS-1:0] p1_pad_pull_en,
    output wire logic [PINS-1:0] p1_pad_analog_en,
    // port 4 pads
    input  wire logic [PINS-1:0] p4_pad_in,
    output wire logic [PINS-1:0] p4_pad_out,
    output wire logic [PINS-1:0] p4_pad_oe,
    output wire logic [PINS-1:0] p4_pad_strong,
    output wire logic [PINS-1:0] p4_pad_pull_en,
    output wire logic [PINS-1:0] p4_pad_analog_en,
    // general-purpose port latches and pin levels
    input  wire logic [PINS-1:0] p1_gpio_d,
    input  wire logic [PINS-1:0] p4_gpio_d,
    output wire logic [PINS-1:0] p1_pin_level,
    output wire logic [PINS-1:0] p4_pin_level,
    // timer 2
    output wire logic            timer2_count_input,
    output wire logic            timer2_trigger_input,
    // second uart
    output wire logic            uart1_receive,
    input  wire logic            uart1_transmit,
    // spi master
    input  wire logic            spi_clock_pin,
    output wire logic            spi_receive_pin,
    input  wire logic            spi_transmit_pin,
    input  wire logic            spi_select_pin,
    // analog converter
    output wire logic [PINS-1:0] analog_channel_input,
    // counter arrays
    input  wire logic [5:0]      counter_module_out,
    input  wire logic [5:0]      counter_module_oe,
    output wire logic [5:0]      counter_module_pin,
    output wire logic            counter_array0_ext_clock,
    output wire logic            counter_array1_ext_clock
);
    import pfs_pkg::*;

    // ============================================================
    // select registers
    wire logic [7:0] port1_function_select_low;
    wire logic [7:0] port1_function_select_high;
    wire logic [7:0] port4_function_select_low;
    wire logic [7:0] port4_function_select_high;
    wire logic [3:0] reg_hit;

    pfs_sfr_reg #(.ADDR(`PFS_ADDR_P1_LOW)) u_p1_low
    (
        .clk       (clk),
        .rst_b     (rst_b),
        .ce        (ce),
        .sfr_addr  (sfr_addr),
        .sfr_wr    (sfr_wr),
        .sfr_wdata (sfr_wdata),
        .hit       (reg_hit[0]),
        .value_r   (port1_function_select_low)
    );

    pfs_sfr_reg #(.ADDR(`PFS_ADDR_P1_HIGH)) u_p1_high
    (
        .clk       (clk),
        .rst_b     (rst_b),
        .ce        (ce),
        .sfr_addr  (sfr_addr),
        .sfr_wr    (sfr_wr),
        .sfr_wdata (sfr_wdata),
        .hit       (reg_hit[1]),
        .value_r   (port1_function_select_high)
    );

    pfs_sfr_reg #(.ADDR(`PFS_ADDR_P4_LOW)) u_p4_low
    (
        .clk       (clk),
        .rst_b     (rst_b),
        .ce        (ce),
        .sfr_addr  (sfr_addr),
        .sfr_wr    (sfr_wr),
        .sfr_wdata (sfr_wdata),
        .hit       (reg_hit[2]),
        .value_r   (port4_function_select_low)
    );

    pfs_sfr_reg #(.ADDR(`PFS_ADDR_P4_HIGH)) u_p4_high
    (
        .clk       (clk),
        .rst_b     (rst_b),
        .ce        (ce),
        .sfr_addr  (sfr_addr),
        .sfr_wr    (sfr_wr),
        .sfr_wdata (sfr_wdata),
        .hit       (reg_hit[3]),
        .value_r   (port4_function_select_high)
    );

    // ============================================================
    // read path, one clock after the read strobe
    wire logic [7:0] read_mux;

    assign sfr_hit  = |reg_hit;
    assign read_mux = reg_hit[0] ? port1_function_select_low  :
                      reg_hit[1] ? port1_function_select_high :
                      reg_hit[2] ? port4_function_select_low  :
                      reg_hit[3] ? port4_function_select_high : 8'h00;  // see [RULE_12]

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            sfr_rdata_r <= 8'h00;
        else if (ce && sfr_rd)
            sfr_rdata_r <= read_mux;
    end

    // ============================================================
    // data driven toward the pads, bit order = pin number
    wire logic [7:0] shared_d;
    wire logic [7:0] counter_d;
    wire logic [7:0] counter_oe;

    // receive and timer pins drive idle high so only the pull-up acts
    assign shared_d   = {spi_select_pin, spi_transmit_pin, `PFS_IDLE_LEVEL, spi_clock_pin,
                         uart1_transmit, `PFS_IDLE_LEVEL, `PFS_IDLE_LEVEL, `PFS_IDLE_LEVEL};
    assign counter_d  = {`PFS_IDLE_LEVEL, counter_module_out[5:3],
                         `PFS_IDLE_LEVEL, counter_module_out[2:0]};
    assign counter_oe = {1'b0, counter_module_oe[5:3], 1'b0, counter_module_oe[2:0]};

    // ============================================================
    // per-pin decode and pad cells
    pfs_func_type    p1_func [PINS];
    pfs_func_type    p4_func [PINS];
    wire logic [PINS-1:0] p1_alt1;
    wire logic [PINS-1:0] p1_alt2;
    wire logic [PINS-1:0] p4_alt1;
    wire logic [PINS-1:0] p4_alt2;

    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++)
        begin : g_pin
            // low bit clear means I/O whatever the high bit holds
            assign p1_func[gi] = !port1_function_select_low[gi]  ? PFS_FUNC_IO   :
                                 !port1_function_select_high[gi] ? PFS_FUNC_ALT1 :
                                                                   PFS_FUNC_ALT2;  // see [RULE_02]
            assign p4_func[gi] = !port4_function_select_low[gi]  ? PFS_FUNC_IO   :
                                 !port4_function_select_high[gi] ? PFS_FUNC_ALT1 :
                                                                   PFS_FUNC_ALT2;  // see [RULE_03]
            assign p1_alt1[gi] = (p1_func[gi] == PFS_FUNC_ALT1);
            assign p1_alt2[gi] = (p1_func[gi] == PFS_FUNC_ALT2);
            assign p4_alt1[gi] = (p4_func[gi] == PFS_FUNC_ALT1);
            assign p4_alt2[gi] = (p4_func[gi] == PFS_FUNC_ALT2);

            // each pin has its own cell fed only by its own select bits
            pfs_pin_cell
            #(
                .ALT1_KIND ((gi < 2) ? PFS_KIND_INPUT : PFS_KIND_FAST),
                .ALT2_KIND (PFS_KIND_ANALOG)
            ) u_p1_cell
            (
                .clk             (clk),
                .rst_b           (rst_b),
                .ce              (ce),
                .func            (p1_func[gi]),   // see [RULE_09]
                .gpio_d          (p1_gpio_d[gi]),
                .alt1_d          (shared_d[gi]),  // see [RULE_04]
                .alt1_oe         (1'b0),
                .alt2_d          (`PFS_IDLE_LEVEL),
                .pad_in          (p1_pad_in[gi]),
                .pad_out_r       (p1_pad_out[gi]),
                .pad_oe_r        (p1_pad_oe[gi]),
                .pad_strong_r    (p1_pad_strong[gi]),
                .pad_pull_en_r   (p1_pad_pull_en[gi]),
                .pad_analog_en_r (p1_pad_analog_en[gi]),
                .level_r         (p1_pin_level[gi])
            );

            pfs_pin_cell
            #(
                .ALT1_KIND ((gi == 3 || gi == 7) ? PFS_KIND_INPUT : PFS_KIND_PUSH),
                .ALT2_KIND ((gi < 2) ? PFS_KIND_INPUT : PFS_KIND_FAST)
            ) u_p4_cell
            (
                .clk             (clk),
                .rst_b           (rst_b),
                .ce              (ce),
                .func            (p4_func[gi]),    // see [RULE_09]
                .gpio_d          (p4_gpio_d[gi]),
                .alt1_d          (counter_d[gi]),  // see [RULE_06] [RULE_07]
                .alt1_oe         (counter_oe[gi]),
                .alt2_d          (shared_d[gi]),   // see [RULE_08]
                .pad_in          (p4_pad_in[gi]),
                .pad_out_r       (p4_pad_out[gi]),
                .pad_oe_r        (p4_pad_oe[gi]),
                .pad_strong_r    (p4_pad_strong[gi]),
                .pad_pull_en_r   (p4_pad_pull_en[gi]),
                .pad_analog_en_r (p4_pad_analog_en[gi]),
                .level_r         (p4_pin_level[gi])
            );
        end
    endgenerate

    // ============================================================
    // routing of pin levels to peripheral inputs
    // port 1 wins when both ports claim the same function
    wire logic [7:0] shared_in;
    wire logic [7:0] counter_in;

    assign shared_in  = (p1_alt1 & p1_pin_level) |
                        (~p1_alt1 & p4_alt2 & p4_pin_level) |
                        (~p1_alt1 & ~p4_alt2);                   // see [RULE_04] [RULE_08]
    assign counter_in = (p4_alt1 & p4_pin_level) | ~p4_alt1;     // see [RULE_06] [RULE_07]

    assign timer2_count_input       = shared_in[0];
    assign timer2_trigger_input     = shared_in[1];
    assign uart1_receive            = shared_in[2];
    assign spi_receive_pin          = shared_in[5];
    assign counter_module_pin       = {counter_in[6:4], counter_in[2:0]};
    assign counter_array0_ext_clock = counter_in[3];
    assign counter_array1_ext_clock = counter_in[7];
    assign analog_channel_input     = p1_alt2;                   // see [RULE_05] [RULE_11]

    // ============================================================
    // checks
    property p_reset_zero;
        @(posedge clk)
        !rst_b |-> (port1_function_select_low == 8'h00) && (port1_function_select_high == 8'h00)
                && (port4_function_select_low == 8'h00) && (port4_function_select_high == 8'h00);
    endproperty
    a_reset_zero : assert property (p_reset_zero) // see [RULE_01]
        else $error("select register not zero during reset");

    property p_write_readback;
        @(posedge clk) disable iff (!rst_b)
        ce && sfr_wr && (sfr_addr == `PFS_ADDR_P4_HIGH) ##1 ce && sfr_rd && !sfr_wr
            && (sfr_addr == `PFS_ADDR_P4_HIGH) |=> sfr_rdata_r == $past(sfr_wdata, 2);
    endproperty
    a_write_readback : assert property (p_write_readback) // see [RULE_12]
        else $error("select register read did not return last write");

    property p_p1_io_any_high;
        @(posedge clk) disable iff (!rst_b)
        !port1_function_select_low[3] |-> (p1_func[3] == PFS_FUNC_IO) && !analog_channel_input[3];
    endproperty
    a_p1_io_any_high : assert property (p_p1_io_any_high) // see [RULE_02]
        else $error("port 1 pin not I/O with low select bit clear");

    property p_p4_decode;
        @(posedge clk) disable iff (!rst_b)
        port4_function_select_low[4] && !port4_function_select_high[4]
            |-> counter_module_pin[3] == p4_pin_level[4];
    endproperty
    a_p4_decode : assert property (p_p4_decode) // see [RULE_03] [RULE_07]
        else $error("port 4 alt1 decode wrong on pin 4");

    property p_timer_p1;
        @(posedge clk) disable iff (!rst_b)
        p1_alt1[0] |-> timer2_count_input == p1_pin_level[0];
    endproperty
    a_timer_p1 : assert property (p_timer_p1) // see [RULE_04]
        else $error("timer 2 count not taken from port 1 pin 0");

    property p_spi_p4;
        @(posedge clk) disable iff (!rst_b)
        p4_alt2[5] && !p1_alt1[5] |-> spi_receive_pin == p4_pin_level[5];
    endproperty
    a_spi_p4 : assert property (p_spi_p4) // see [RULE_08]
        else $error("spi receive not taken from port 4 pin 5");

    property p_analog_map;
        @(posedge clk) disable iff (!rst_b)
        analog_channel_input == (port1_function_select_low & port1_function_select_high);
    endproperty
    a_analog_map : assert property (p_analog_map) // see [RULE_05]
        else $error("analog channel select does not follow port 1 alt2");

    property p_pca0_clock;
        @(posedge clk) disable iff (!rst_b)
        p4_alt1[3] |-> counter_array0_ext_clock == p4_pin_level[3];
    endproperty
    a_pca0_clock : assert property (p_pca0_clock) // see [RULE_06]
        else $error("counter array 0 clock not from port 4 pin 3");

    property p_independent;
        @(posedge clk) disable iff (!rst_b)
        ce && sfr_wr && (sfr_addr == `PFS_ADDR_P1_LOW)
            |=> $stable(port4_function_select_low) && $stable(port4_function_select_high)
                && $stable(port1_function_select_high);
    endproperty
    a_independent : assert property (p_independent) // see [RULE_09]
        else $error("write to one select register changed another");

    property p_analog_pad;
        @(posedge clk) disable iff (!rst_b)
        ce && p1_alt2[6] |=> p1_pad_analog_en[6] && !p1_pad_oe[6] && !p1_pad_pull_en[6];
    endproperty
    a_analog_pad : assert property (p_analog_pad) // see [RULE_11]
        else $error("analog pad on port 1 pin 6 still driven");

endmodule // pfs_port_select
`default_nettype wire

/* inc/pfs_regs.svh */
// register offsets, reset values and widths of the port 1 / port 4 function select block
// assumes an 8-bit special-function register space addressed by an 8-bit address
`ifndef PFS_REGS_SVH
`define PFS_REGS_SVH

// ============================================================
// special-function register offsets
`define PFS_ADDR_P1_LOW   8'h8e
`define PFS_ADDR_P1_HIGH  8'h8f
`define PFS_ADDR_P4_LOW   8'h92
`define PFS_ADDR_P4_HIGH  8'h93

// ============================================================
// reset values and sizes
`define PFS_SEL_RESET     8'h00
`define PFS_PORT_PINS     8
`define PFS_SYNC_STAGES   3
`define PFS_IDLE_LEVEL    1'b1

`endif

/* inc/pfs_pkg.sv */
// types shared by the port function select block
// assumes nothing beyond a SystemVerilog elaborator
package pfs_pkg;

    // ============================================================
    // function chosen for one pin, gray along io -> alt1 -> alt2
    typedef enum logic [1:0]
    {
        PFS_FUNC_IO   = 2'h0,
        PFS_FUNC_ALT1 = 2'h1,
        PFS_FUNC_ALT2 = 2'h3
    } pfs_func_type;

    // ============================================================
    // electrical behaviour of the pad for a function
    typedef enum logic [2:0]
    {
        PFS_KIND_QUASI  = 3'h0,
        PFS_KIND_FAST   = 3'h1,
        PFS_KIND_INPUT  = 3'h3,
        PFS_KIND_PUSH   = 3'h2,
        PFS_KIND_ANALOG = 3'h6
    } pfs_kind_type;

endpackage : pfs_pkg

/* logic/pfs_sfr_reg.sv */
// one 8-bit function select register in the special-function space
// assumes a single-cycle write strobe from the core on the block clock
`timescale 1ns/1ns
`default_nettype none
`include "pfs_regs.svh"

module pfs_sfr_reg
#(
    parameter logic [7:0] ADDR = `PFS_ADDR_P1_LOW
)
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       ce,
    // core access
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    // register state
    output wire logic       hit,
    output logic      [7:0] value_r
);
    import pfs_pkg::*;

    wire logic write_en;

    assign hit      = (sfr_addr == ADDR);
    assign write_en = ce && sfr_wr && hit;

    // ============================================================
    // storage
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            value_r <= `PFS_SEL_RESET;   // see [RULE_01]
        else if (write_en)
            value_r <= sfr_wdata;        // see [RULE_12]
    end

endmodule // pfs_sfr_reg
`default_nettype wire

/* logic/pfs_pin_cell.sv */
// one port pin: drive control for the chosen function and a filtered input level
// assumes pad_in comes from the package pin, outside the clock domain
`timescale 1ns/1ns
`default_nettype none
`include "pfs_regs.svh"

module pfs_pin_cell
#(
    parameter pfs_pkg::pfs_kind_type ALT1_KIND = pfs_pkg::PFS_KIND_FAST,
    parameter pfs_pkg::pfs_kind_type ALT2_KIND = pfs_pkg::PFS_KIND_FAST
)
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 ce,
    // selection and data to drive
    input  wire pfs_pkg::pfs_func_type func,
    input  wire logic                 gpio_d,
    input  wire logic                 alt1_d,
    input  wire logic                 alt1_oe,
    input  wire logic                 alt2_d,
    // pad
    input  wire logic                 pad_in,
    output logic                      pad_out_r,
    output logic                      pad_oe_r,
    output logic                      pad_strong_r,
    output logic                      pad_pull_en_r,
    output logic                      pad_analog_en_r,
    // filtered level
    output logic                      level_r
);
    import pfs_pkg::*;

    logic [`PFS_SYNC_STAGES-1:0] sync_r;
    logic                        d_prev_r;
    pfs_kind_type                kind;
    logic                        d_raw;
    logic                        d_sel;
    logic                        is_push;
    logic                        is_analog;
    logic                        strong_nxt;
    logic                        oe_nxt;

    assign kind       = (func == PFS_FUNC_ALT1) ? ALT1_KIND :
                        (func == PFS_FUNC_ALT2) ? ALT2_KIND : PFS_KIND_QUASI;
    assign d_raw      = (func == PFS_FUNC_ALT1) ? alt1_d :
                        (func == PFS_FUNC_ALT2) ? alt2_d : gpio_d;
    // input-only functions hold the pin released high
    assign d_sel      = (kind == PFS_KIND_INPUT) ? `PFS_IDLE_LEVEL : d_raw;
    assign is_push    = (kind == PFS_KIND_PUSH) && alt1_oe;
    assign is_analog  = (kind == PFS_KIND_ANALOG);
    assign strong_nxt = is_push ? d_sel
                      : ((kind == PFS_KIND_FAST) && d_sel && !d_prev_r);  // see [RULE_10]
    assign oe_nxt     = is_analog ? 1'b0
                      : (is_push || !d_sel || strong_nxt);                 // see [RULE_11]

    // ============================================================
    // pad drive
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            d_prev_r        <= 1'b1;
            pad_out_r       <= 1'b1;
            pad_oe_r        <= 1'b0;
            pad_strong_r    <= 1'b0;
            pad_pull_en_r   <= 1'b1;
            pad_analog_en_r <= 1'b0;
        end
        else if (ce)
        begin
            d_prev_r        <= d_sel;
            pad_out_r       <= d_sel;
            pad_oe_r        <= oe_nxt;
            pad_strong_r    <= strong_nxt && !is_analog;  // see [RULE_10]
            pad_pull_en_r   <= !is_analog && !is_push;    // see [RULE_11]
            pad_analog_en_r <= is_analog;                 // see [RULE_11]
        end
    end

    // ============================================================
    // input filter: level moves once the last two stages agree
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync_r  <= {`PFS_SYNC_STAGES{1'b1}};
            level_r <= 1'b1;
        end
        else if (ce)
        begin
            sync_r <= {sync_r[`PFS_SYNC_STAGES-2:0], pad_in};
            if (sync_r[1] == sync_r[2])
                level_r <= sync_r[2];
        end
    end

    // ============================================================
    // checks
    sequence s_fast_rise;
        ce && (kind == PFS_KIND_FAST) && d_sel && !d_prev_r;
    endsequence

    sequence s_one_strong;
        pad_strong_r ##1 !pad_strong_r;
    endsequence

    property p_strong_one_cycle;
        @(posedge clk) disable iff (!rst_b)
        s_fast_rise ##1 ce |-> s_one_strong;
    endproperty
    a_strong_one_cycle : assert property (p_strong_one_cycle) // see [RULE_10]
        else $error("strong high driver not on for exactly one clock");

    property p_analog_quiet;
        @(posedge clk) disable iff (!rst_b)
        ce && is_analog |=> !pad_oe_r && !pad_pull_en_r && !pad_strong_r && pad_analog_en_r;
    endproperty
    a_analog_quiet : assert property (p_analog_quiet) // see [RULE_11]
        else $error("analog pin still has a driver or pull-up on");

endmodule // pfs_pin_cell
`default_nettype wire

/* bench/pfs_pins_model.sv */
// pad model: pull-up pins the bench may hold low
// assumes pad_oe is high while the block drives the pin
`timescale 1ns/1ns
`default_nettype none

module pfs_pins_model
(
    // block side
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe,
    input  wire logic [7:0] pull_low,
    // pin levels
    output wire logic [7:0] pad_in
);
    // ============================================================
    // driven pins follow the block, released pins float up
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ~pull_low);
endmodule // pfs_pins_model

`default_nettype wire

/* bench/pfs_port_select_tb.sv */
// self-checking bench for the port 1 / port 4 function select block
// assumes pfs_pins_model on both ports and a 250 MHz clock
`timescale 1ns/1ns
`default_nettype none
`include "pfs_regs.svh"

module pfs_port_select_tb;
    logic       clk, rst_b, sfr_wr, sfr_rd, uart_tx, spi_lvl, t2c, t2t, ck0, ck1, hit, urx, srx;
    logic [7:0] sfr_addr, sfr_wdata, rdata, gpio_d, p1_low, p4_low, ana;
    logic [7:0] p1_out, p1_oe, p1_st, p1_pull, p1_an, p4_out, p4_oe, p1_in, p4_in;
    logic [5:0] cm_pin, cm_out, cm_oe;
    logic [7:0] addrs [4] = '{`PFS_ADDR_P1_LOW, `PFS_ADDR_P1_HIGH, `PFS_ADDR_P4_LOW, `PFS_ADDR_P4_HIGH};
    int         fails = 0;
    int         total_checks = 0;

    pfs_port_select dut_u
    (
        .clk(clk), .rst_b(rst_b), .ce(1'b1), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_hit(hit), .sfr_rdata_r(rdata),
        .p1_pad_in(p1_in), .p1_pad_out(p1_out), .p1_pad_oe(p1_oe), .p1_pad_strong(p1_st),
        .p1_pad_pull_en(p1_pull), .p1_pad_analog_en(p1_an), .p4_pad_in(p4_in),
        .p4_pad_out(p4_out), .p4_pad_oe(p4_oe), .p4_pad_strong(), .p4_pad_pull_en(),
        .p4_pad_analog_en(), .p1_gpio_d(gpio_d), .p4_gpio_d(gpio_d), .p1_pin_level(),
        .p4_pin_level(), .timer2_count_input(t2c), .timer2_trigger_input(t2t),
        .uart1_receive(urx), .uart1_transmit(uart_tx), .spi_clock_pin(spi_lvl),
        .spi_receive_pin(srx), .spi_transmit_pin(spi_lvl), .spi_select_pin(spi_lvl),
        .analog_channel_input(ana), .counter_module_out(cm_out), .counter_module_oe(cm_oe),
        .counter_module_pin(cm_pin), .counter_array0_ext_clock(ck0),
        .counter_array1_ext_clock(ck1)
    );
    pfs_pins_model p1_pins_u (.pad_out(p1_out), .pad_oe(p1_oe), .pull_low(p1_low), .pad_in(p1_in));
    pfs_pins_model p4_pins_u (.pad_out(p4_out), .pad_oe(p4_oe), .pull_low(p4_low), .pad_in(p4_in));

    // ============================================================
    // bus and compare helpers
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1 v = rdata;
    endtask

    // ============================================================
    // scenarios
    task automatic t_reset();
        logic [7:0] v;
        chk(p1_pull, 8'hff);
        chk(p1_an, 8'h00);
        foreach (addrs[i])
        begin
            rd(addrs[i], v);
            chk(v, `PFS_SEL_RESET);
        end
        $display("test reset done");
    endtask
    task automatic t_regs();
        logic [7:0] v;
        foreach (addrs[i]) wr(addrs[i], 8'h3c + 8'(i));
        wr(8'h90, 8'ha5);
        foreach (addrs[i])
        begin
            rd(addrs[i], v);
            chk(v, 8'h3c + 8'(i));
        end
        rd(8'h90, v);
        chk(v, 8'h00);
        chk(8'(hit), 8'h00);
        // write then read the same register on the very next edge
        @(posedge clk);
        sfr_addr <= `PFS_ADDR_P4_HIGH;
        sfr_wdata <= 8'h5a;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1 chk(rdata, 8'h5a);
        foreach (addrs[i]) wr(addrs[i], 8'h00);
        $display("test registers done");
    endtask
    task automatic t_port1();
        wr(8'h8e, 8'hff);
        wr(8'h8f, 8'hff);
        cyc(2);
        chk(ana, 8'hff);
        chk(p1_an, 8'hff);
        chk(p1_oe | p1_pull | p1_st, 8'h00);
        wr(8'h8f, 8'h0f);
        cyc(2);
        chk(ana, 8'h0f);
        wr(8'h8e, 8'h08);
        wr(8'h8f, 8'h00);
        cyc(2);
        chk(ana, 8'h00);
        chk(8'({p1_oe[3], p1_out[3]}), 8'h02);
        @(posedge clk);
        uart_tx <= 1'b1;
        cyc(1);
        chk(p1_st, 8'h08);
        cyc(1);
        chk(p1_st, 8'h00);
        wr(8'h8e, 8'h00);
        $display("test port1 done");
    endtask
    task automatic t_port4();
        wr(8'h92, 8'hff);
        p4_low <= 8'h8b;
        cyc(6);
        chk(8'(cm_pin), 8'h3c);
        chk(8'({ck1, ck0}), 8'h00);
        wr(8'h93, 8'hff);
        p4_low <= 8'h27;
        cyc(6);
        chk(8'({t2c, t2t, cm_pin}), 8'h3f);
        chk(8'({urx, srx}), 8'h00);
        $display("test port4 done");
    endtask

    // ============================================================
    // run control
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        #40000;
        fails++;
        tally_and_finish();
    end
    initial
    begin
        {sfr_wr, sfr_rd, uart_tx, sfr_addr, sfr_wdata, p1_low, p4_low} = '0;
        // counter outputs idle high so module pins stay released
        {rst_b, spi_lvl, gpio_d, cm_out, cm_oe} = {2'b11, 8'hff, 6'h3f, 6'h00};
        // reset falls after time zero so the asynchronous reset sees an edge
        #1 rst_b = 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        cyc(1);
        t_reset();
        t_regs();
        t_port1();
        t_port4();
        tally_and_finish();
    end
endmodule // pfs_port_select_tb

`default_nettype wire
